/* verilog/pcsd_top.sv */
// Pulse counter status register, high debounce register, integrators and quadrature tracking.
`timescale 1ns/100ps
module pcsd_top (
	input wire logic sys_clk_i, // System clock, 125 MHz.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic ce_i, // Clock enable, freezes all state when low.
	input wire pcsd_pkg::pcsd_sfr_req_t sfr_req_i, // Register bus request.
	output logic [7:0] sfr_rdata_o, // Read data, one cycle after a read.
	input wire logic [1:0] count_mode_sel_i, // Counter mode setting.
	input wire logic fallback_on_flutter_i, // Drop to dual counting during flutter.
	input wire logic sample_tick_i, // Sample-rate tick, one cycle.
	input wire logic [7:0] deb_low_i, // Low debounce setting.
	input wire logic input_a_i, // First reed switch level.
	input wire logic input_b_i, // Second reed switch level.
	output logic [7:0] counter_status_o, // Live status byte.
	output logic [1:0] eff_mode_o, // Mode actually in effect.
	output logic [7:0] debounce_high_count_o // High debounce setting.
);
	import pcsd_pkg::*;

	logic [7:0] deb_high_r; // High debounce register.
	logic [7:0] deb_high_nxt; // Next high debounce value.
	logic [7:0] rdata_r; // Read data register.
	logic [7:0] rdata_nxt; // Next read data.
	logic a_now; // First input, debounced.
	logic a_prev; // First input, previous.
	logic b_now; // Second input, debounced.
	logic b_prev; // Second input, previous.
	logic tick_d_r; // Tick delayed to line up with updated integrators.
	pcsd_state_t state_r; // Quadrature position state.
	pcsd_state_t state_nxt; // Next position.
	logic dir_r; // Direction bit.
	logic dir_nxt; // Next direction.
	logic [7:0] rise_a_r, rise_b_r, fall_a_r, fall_b_r; // Edge counts per input.
	logic [7:0] rise_a_nxt, rise_b_nxt, fall_a_nxt, fall_b_nxt; // Next edge counts.
	logic flutter; // Edge count disparity.
	logic [7:0] status_nxt; // Status byte to register.
	logic [7:0] status_r; // Registered status byte.
	logic [1:0] eff_nxt; // Mode in effect, next.
	logic [1:0] eff_r; // Mode in effect.
	pcsd_mode_t mode; // Decoded mode.
	pcsd_integ_t integ; // Integrator outputs gathered.

	// One integrator per input, sharing the two thresholds.
	logic [1:0] raw_in; // Raw levels, index 0 is the first input.
	logic [1:0] now_v; // Debounced levels.
	logic [1:0] prev_v; // Previous levels.
	assign raw_in = {input_b_i, input_a_i};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_integ
			pcsd_integrator u_integ (
				.sys_clk_i(sys_clk_i),
				.rst_i(rst_i),
				.ce_i(ce_i),
				.tick_i(sample_tick_i),
				.in_i(raw_in[gi]),
				.deb_high_i(deb_high_r),
				.deb_low_i(deb_low_i),
				.now_o(now_v[gi]),
				.prev_o(prev_v[gi])
			);
		end
	endgenerate
	assign a_now = now_v[0];
	assign b_now = now_v[1];
	assign a_prev = prev_v[0];
	assign b_prev = prev_v[1];
	assign integ = '{b_prev: b_prev, a_prev: a_prev, b_now: b_now, a_now: a_now};
	assign mode = pcsd_mode_t'(count_mode_sel_i);

	// Decodes whether a register access hits a given address; used by write and read paths.
	function automatic logic hit(input pcsd_sfr_req_t r, input logic [7:0] a);
		hit = (r.addr == a);
	endfunction

	// Register write and read paths; unmapped reads return zero.
	always_comb begin
		deb_high_nxt = deb_high_r;
		rdata_nxt = rdata_r;
		if (sfr_req_i.wr && hit(sfr_req_i, PCSD_ADDR_DEB_HIGH)) begin
			deb_high_nxt = sfr_req_i.wdata;
		end
		if (sfr_req_i.rd) begin
			if (hit(sfr_req_i, PCSD_ADDR_STATUS)) begin
				rdata_nxt = status_r;
			end else if (hit(sfr_req_i, PCSD_ADDR_DEB_HIGH)) begin
				rdata_nxt = deb_high_r;
			end else begin
				rdata_nxt = 8'h00;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			deb_high_r <= PCSD_DEB_HIGH_RST;
			rdata_r <= 8'h00;
		end else if (ce_i) begin
			deb_high_r <= deb_high_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Quadrature tracking acts one cycle after the tick, once the integrators have updated.
	// Edge counts only matter in quadrature mode, so they are held cleared otherwise.
	always_comb begin
		state_nxt = pcsd_state_t'({b_now, b_now ^ a_now});
		dir_nxt = dir_r;
		rise_a_nxt = rise_a_r;
		rise_b_nxt = rise_b_r;
		fall_a_nxt = fall_a_r;
		fall_b_nxt = fall_b_r;
		case (mode)
			PCSD_MODE_QUAD: begin
				if (tick_d_r) begin
					// Gray position advancing by one is counter clockwise, retreating is clockwise.
					if (state_nxt == pcsd_state_t'(state_r + 2'b01)) begin
						dir_nxt = 1'b0;
					end else if (state_nxt == pcsd_state_t'(state_r - 2'b01)) begin
						dir_nxt = 1'b1;
					end
					if (a_now && !a_prev) rise_a_nxt = rise_a_r + 8'h01;
					if (b_now && !b_prev) rise_b_nxt = rise_b_r + 8'h01;
					if (!a_now && a_prev) fall_a_nxt = fall_a_r + 8'h01;
					if (!b_now && b_prev) fall_b_nxt = fall_b_r + 8'h01;
				end
			end
			default: begin
				// Direction and flutter have no meaning outside quadrature.
				dir_nxt = 1'b0;
				rise_a_nxt = 8'h00;
				rise_b_nxt = 8'h00;
				fall_a_nxt = 8'h00;
				fall_b_nxt = 8'h00;
			end
		endcase
	end

	// Counts wrap together, so equality survives overflow as long as both inputs move alike.
	assign flutter = (rise_a_r != rise_b_r) || (fall_a_r != fall_b_r);

	// Mode in effect and the status byte, both registered so outputs come from flops.
	always_comb begin
		eff_nxt = count_mode_sel_i;
		if (mode == PCSD_MODE_QUAD && fallback_on_flutter_i && flutter) begin
			eff_nxt = PCSD_MODE_DUAL;
		end
		status_nxt = 8'h00;
		status_nxt[PCSD_ST_FLUTTER] = flutter && (mode == PCSD_MODE_QUAD);
		status_nxt[PCSD_ST_DIR] = dir_r;
		status_nxt[PCSD_ST_STATE_HI:PCSD_ST_STATE_LO] = state_r;
		status_nxt[PCSD_ST_B_PREV] = integ.b_prev;
		status_nxt[PCSD_ST_A_PREV] = integ.a_prev;
		status_nxt[PCSD_ST_B_NOW] = integ.b_now;
		status_nxt[PCSD_ST_A_NOW] = integ.a_now;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tick_d_r <= 1'b0;
			state_r <= PCSD_POS_LL;
			dir_r <= 1'b0;
			rise_a_r <= 8'h00;
			rise_b_r <= 8'h00;
			fall_a_r <= 8'h00;
			fall_b_r <= 8'h00;
			status_r <= 8'h00;
			eff_r <= PCSD_MODE_OFF;
		end else if (ce_i) begin
			tick_d_r <= sample_tick_i;
			state_r <= state_nxt;
			dir_r <= dir_nxt;
			rise_a_r <= rise_a_nxt;
			rise_b_r <= rise_b_nxt;
			fall_a_r <= fall_a_nxt;
			fall_b_r <= fall_b_nxt;
			status_r <= status_nxt;
			eff_r <= eff_nxt;
		end
	end

	assign sfr_rdata_o = rdata_r;
	assign counter_status_o = status_r;
	assign eff_mode_o = eff_r;
	assign debounce_high_count_o = deb_high_r;

	// A debounce write is visible on the next cycle.
	sequence s_deb_write;
		ce_i && sfr_req_i.wr && sfr_req_i.addr == PCSD_ADDR_DEB_HIGH;
	endsequence
	chk_deb_write_lands: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s_deb_write |=> debounce_high_count_o == $past(sfr_req_i.wdata))
		else $error("high debounce write lost");
	chk_status_now_bits: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i |=> counter_status_o[PCSD_ST_B_NOW:PCSD_ST_A_NOW] == $past({b_now, a_now}))
		else $error("current outputs wrong in status");
	chk_status_prev_bits: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i |=> counter_status_o[PCSD_ST_B_PREV:PCSD_ST_A_PREV] == $past({b_prev, a_prev}))
		else $error("previous outputs wrong in status");
	chk_flutter_quad_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && mode != PCSD_MODE_QUAD ##1 ce_i |=> !counter_status_o[PCSD_ST_FLUTTER])
		else $error("flutter outside quadrature");
	chk_fallback_dual: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && mode == PCSD_MODE_QUAD && fallback_on_flutter_i && flutter |=> eff_mode_o == PCSD_MODE_DUAL)
		else $error("no fallback to dual on flutter");
	chk_quad_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && mode == PCSD_MODE_QUAD && !fallback_on_flutter_i |=> eff_mode_o == PCSD_MODE_QUAD)
		else $error("quadrature left without fallback");
	// The status copy of the direction only moves on an enabled edge, so a frozen edge is excused.
	chk_dir_ccw: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && mode == PCSD_MODE_QUAD && tick_d_r && state_r == PCSD_POS_LL && state_nxt == PCSD_POS_LH
		|=> !dir_r ##1 (!$past(ce_i) || !counter_status_o[PCSD_ST_DIR]))
		else $error("direction not counter clockwise");
	chk_state_field: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i |=> counter_status_o[PCSD_ST_STATE_HI:PCSD_ST_STATE_LO] == $past(state_r))
		else $error("state field mismatch");
endmodule

/* verilog/pcsd_pkg.sv */
// Package with register map, field positions, reset values and shared types of the pulse counter status block.
package pcsd_pkg;
	// Special-function register addresses.
	localparam logic [7:0] PCSD_ADDR_STATUS = 8'hc1;
	localparam logic [7:0] PCSD_ADDR_DEB_HIGH = 8'hfa;
	// Reset value of the high debounce setting.
	localparam logic [7:0] PCSD_DEB_HIGH_RST = 8'h04;
	// Status field positions.
	localparam int PCSD_ST_FLUTTER = 7;
	localparam int PCSD_ST_DIR = 6;
	localparam int PCSD_ST_STATE_HI = 5;
	localparam int PCSD_ST_STATE_LO = 4;
	localparam int PCSD_ST_B_PREV = 3;
	localparam int PCSD_ST_A_PREV = 2;
	localparam int PCSD_ST_B_NOW = 1;
	localparam int PCSD_ST_A_NOW = 0;
	// Low debounce value that bypasses the integrators.
	localparam logic [7:0] PCSD_DEB_OFF = 8'h00;
	// Counter modes.
	typedef enum logic [1:0] {
		PCSD_MODE_OFF = 2'b00,
		PCSD_MODE_SINGLE = 2'b01,
		PCSD_MODE_DUAL = 2'b10,
		PCSD_MODE_QUAD = 2'b11
	} pcsd_mode_t;
	// Quadrature position, named by {input_b, input_a}.
	typedef enum logic [1:0] {
		PCSD_POS_LL = 2'b00,
		PCSD_POS_LH = 2'b01,
		PCSD_POS_HH = 2'b10,
		PCSD_POS_HL = 2'b11
	} pcsd_state_t;
	// Register bus request group.
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} pcsd_sfr_req_t;
	// Integrator pair outputs.
	typedef struct packed {
		logic b_prev;
		logic a_prev;
		logic b_now;
		logic a_now;
	} pcsd_integ_t;
endpackage

/* verilog/pcsd_integrator.sv */
// Single-input up/down debounce integrator with previous-output capture.
`timescale 1ns/100ps
module pcsd_integrator
	import pcsd_pkg::*;
(
	input wire logic sys_clk_i, // System clock.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic ce_i, // Clock enable, freezes state when low.
	input wire logic tick_i, // Sample tick, one cycle.
	input wire logic in_i, // Raw switch level.
	input wire logic [7:0] deb_high_i, // Net highs needed, minus one.
	input wire logic [7:0] deb_low_i, // Net lows needed, minus one.
	output logic now_o, // Current debounced output.
	output logic prev_o // Output before the last tick.
);
	logic [8:0] cnt_r; // Net count toward a change of output.
	logic [8:0] cnt_nxt; // Next count.
	logic now_r; // Debounced level.
	logic now_nxt; // Next debounced level.
	logic prev_r; // Previous debounced level.
	logic prev_nxt; // Next previous level.
	logic [8:0] need; // Threshold for the pending change.

	// The counter runs toward the opposite level: disagreeing samples add, agreeing ones take away.
	// Counting net samples, not consecutive ones, lets bounce settle cumulatively.
	always_comb begin
		cnt_nxt = cnt_r;
		now_nxt = now_r;
		prev_nxt = prev_r;
		need = now_r ? ({1'b0, deb_low_i} + 9'h001) : ({1'b0, deb_high_i} + 9'h001);
		if (tick_i) begin
			prev_nxt = now_r;
			if (deb_low_i == PCSD_DEB_OFF) begin
				// A zero low setting bypasses filtering entirely.
				now_nxt = in_i;
				cnt_nxt = 9'h000;
			end else if (in_i != now_r) begin
				if (cnt_r + 9'h001 >= need) begin
					now_nxt = in_i;
					cnt_nxt = 9'h000;
				end else begin
					cnt_nxt = cnt_r + 9'h001;
				end
			end else if (cnt_r != 9'h000) begin
				cnt_nxt = cnt_r - 9'h001;
			end
		end
	end

	// Registers only.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cnt_r <= 9'h000;
			now_r <= 1'b0;
			prev_r <= 1'b0;
		end else if (ce_i) begin
			cnt_r <= cnt_nxt;
			now_r <= now_nxt;
			prev_r <= prev_nxt;
		end
	end

	assign now_o = now_r;
	assign prev_o = prev_r;

	// Each tick keeps the old output, and a disagreeing input only counts until the threshold is met.
	chk_integ_prev_copy: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && tick_i |=> prev_r == $past(now_r))
		else $error("previous output not copied at tick");
	chk_integ_no_early: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && tick_i && deb_low_i != PCSD_DEB_OFF && !now_r && cnt_r + 9'h001 < need |=> !now_r)
		else $error("integrator went high too early");
	chk_integ_count_up: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && tick_i && deb_low_i != PCSD_DEB_OFF && in_i != now_r && cnt_r + 9'h001 < need
		|=> cnt_r == $past(cnt_r) + 9'h001)
		else $error("integrator did not count");
endmodule

/* dv/pcsd_reed_model.sv */
// Behavioural pair of reed switches turned by a magnet wheel, with a commanded fault on the first switch.
`timescale 1ns/100ps
module pcsd_reed_model (
	input wire logic sys_clk_i, // Bench clock.
	input wire logic step_i, // Move the wheel one position.
	input wire logic rev_i, // Move backwards when high.
	input wire logic flip_a_i, // Toggle the first switch alone.
	output logic input_a_o, // First switch level.
	output logic input_b_o // Second switch level.
);
	logic [1:0] pos_r = 2'h0; // Wheel position as a binary count; the switch levels are its gray code.
	logic fault_r = 1'b0; // Extra toggle of the first switch.
	// A healthy wheel changes one switch per step; a flip breaks the pairing on purpose.
	always @(posedge sys_clk_i) begin
		if (step_i) begin
			pos_r <= rev_i ? pos_r - 2'h1 : pos_r + 2'h1;
		end
		if (flip_a_i) begin
			fault_r <= ~fault_r;
		end
	end
	// Levels follow the position at once, there is no settling to model.
	assign input_b_o = pos_r[1];
	assign input_a_o = pos_r[1] ^ pos_r[0] ^ fault_r;
endmodule

/* dv/pulse_counter_status_debounce_high_tb.sv */
// Self-checking bench for the pulse counter status and high debounce block.
`timescale 1ns/100ps
module pulse_counter_status_debounce_high_tb;
	import pcsd_pkg::*;
	logic sys_clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, fallback_on_flutter_i = 1'b0, sample_tick_i = 1'b0;
	logic [1:0] count_mode_sel_i = 2'h0; // Requested mode.
	logic [7:0] deb_low_i = 8'h02; // Low debounce setting.
	pcsd_sfr_req_t sfr_req_i = '0; // Register request.
	logic input_a_i, input_b_i, step, rev = 1'b0, flip = 1'b0;
	logic [7:0] sfr_rdata_o, counter_status_o, debounce_high_count_o, v;
	logic [1:0] eff_mode_o, p, pp;
	int mismatches = 0;
	int comparisons = 0;
	int n;
	initial step = 1'b0;
	pcsd_top DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .sfr_req_i(sfr_req_i),
		.sfr_rdata_o(sfr_rdata_o), .count_mode_sel_i(count_mode_sel_i),
		.fallback_on_flutter_i(fallback_on_flutter_i), .sample_tick_i(sample_tick_i), .deb_low_i(deb_low_i),
		.input_a_i(input_a_i), .input_b_i(input_b_i), .counter_status_o(counter_status_o),
		.eff_mode_o(eff_mode_o), .debounce_high_count_o(debounce_high_count_o));
	pcsd_reed_model reed (.sys_clk_i(sys_clk_i), .step_i(step), .rev_i(rev), .flip_a_i(flip),
		.input_a_o(input_a_i), .input_b_o(input_b_i));
	// Free-running 125 MHz clock.
	initial begin
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	// Prints the counts and the verdict, then stops the run.
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Case inequality, so an unknown never counts as a match.
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One register access; the request is held for exactly the edge that takes it.
	task automatic sfr(input logic [7:0] addr, input logic wr, input logic [7:0] wdata);
		@(posedge sys_clk_i);
		sfr_req_i <= '{addr: addr, wr: wr, rd: ~wr, wdata: wdata};
		@(posedge sys_clk_i);
		sfr_req_i <= '0;
		#1;
	endtask
	// One sample tick, then enough edges for direction and flutter to reach the status.
	task automatic tick();
		@(posedge sys_clk_i);
		sample_tick_i <= 1'b1;
		@(posedge sys_clk_i);
		sample_tick_i <= 1'b0;
		repeat (5) @(posedge sys_clk_i);
		#1;
	endtask
	// Commands the switch model for one edge.
	task automatic move(input logic r, input logic s, input logic f);
		@(posedge sys_clk_i);
		rev <= r;
		step <= s;
		flip <= f;
		@(posedge sys_clk_i);
		step <= 1'b0;
		flip <= 1'b0;
	endtask
	// Status byte expected from a wheel position and the one before it.
	function automatic logic [7:0] quad_status(input logic dr, input logic [1:0] q, input logic [1:0] qp);
		return {1'b0, dr, q, qp[1], qp[1] ^ qp[0], q[1], q[1] ^ q[0]};
	endfunction
	// Watchdog far beyond the expected run of under a thousand cycles.
	initial begin
		repeat (5000) @(posedge sys_clk_i);
		mismatches++;
		tally_and_finish();
	end
	// Main sequence.
	initial begin
		void'($urandom(79));
		repeat (12) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		#1;
		check("debounce_high_count", PCSD_DEB_HIGH_RST, debounce_high_count_o);
		check("counter_status", 8'h00, counter_status_o);
		v = 8'($urandom);
		sfr(PCSD_ADDR_DEB_HIGH, 1'b1, v);
		sfr(PCSD_ADDR_DEB_HIGH, 1'b0, 8'h00);
		check("debounce_high_read", v, sfr_rdata_o);
		// A write taken while the clock enable is low must be lost.
		@(posedge sys_clk_i);
		ce_i <= 1'b0;
		sfr(PCSD_ADDR_DEB_HIGH, 1'b1, ~v);
		@(posedge sys_clk_i);
		ce_i <= 1'b1;
		sfr(PCSD_ADDR_DEB_HIGH, 1'b0, 8'h00);
		check("debounce_high_frozen", v, sfr_rdata_o);
		sfr(PCSD_ADDR_STATUS, 1'b1, 8'hff);
		sfr(PCSD_ADDR_STATUS, 1'b0, 8'h00);
		check("status_read_only", 8'h00, sfr_rdata_o);
		sfr(8'h5a, 1'b0, 8'h00);
		check("unmapped_read", 8'h00, sfr_rdata_o);
		$display("Register test done");
		// High needs setting plus one net highs; a low sample in between takes one back.
		@(posedge sys_clk_i);
		count_mode_sel_i <= PCSD_MODE_SINGLE;
		n = $urandom_range(6, 1);
		sfr(PCSD_ADDR_DEB_HIGH, 1'b1, 8'(n));
		move(1'b0, 1'b0, 1'b1);
		repeat (n) tick();
		move(1'b0, 1'b0, 1'b1);
		tick();
		move(1'b0, 1'b0, 1'b1);
		tick();
		check("status_low_nibble", 8'h00, counter_status_o & 8'h0f);
		tick();
		check("status_low_nibble", 8'h01, counter_status_o & 8'h0f);
		tick();
		check("status_low_nibble", 8'h05, counter_status_o & 8'h0f);
		$display("Integrator test done");
		// Quadrature walk with integrators bypassed, backwards first so a stuck direction shows.
		@(posedge sys_clk_i);
		deb_low_i <= PCSD_DEB_OFF;
		count_mode_sel_i <= PCSD_MODE_QUAD;
		move(1'b0, 1'b0, 1'b1);
		tick();
		p = 2'h0;
		for (int i = 0; i < 8; i++) begin
			move(i < 4, 1'b1, 1'b0);
			pp = p;
			p = (i < 4) ? p - 2'h1 : p + 2'h1;
			tick();
			sfr(PCSD_ADDR_STATUS, 1'b0, 8'h00);
			check("status_read", quad_status(i < 4, p, pp), sfr_rdata_o & 8'h7f);
		end
		$display("Direction test done");
		// Every mode in turn; quadrature is entered last, so no edges have been counted yet.
		@(posedge sys_clk_i);
		fallback_on_flutter_i <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			@(posedge sys_clk_i);
			count_mode_sel_i <= 2'(m);
			repeat (4) @(posedge sys_clk_i);
			#1;
			check("eff_mode", 8'(m), {6'h00, eff_mode_o});
		end
		check("flutter", 8'h00, counter_status_o & 8'h80);
		// One switch rises and falls while the other stays put.
		move(1'b0, 1'b0, 1'b1);
		tick();
		move(1'b0, 1'b0, 1'b1);
		tick();
		check("flutter", 8'h80, counter_status_o & 8'h80);
		check("eff_mode", 8'h02, {6'h00, eff_mode_o});
		@(posedge sys_clk_i);
		fallback_on_flutter_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		#1;
		check("eff_mode", 8'h03, {6'h00, eff_mode_o});
		@(posedge sys_clk_i);
		count_mode_sel_i <= PCSD_MODE_OFF;
		repeat (4) @(posedge sys_clk_i);
		#1;
		check("flutter", 8'h00, counter_status_o & 8'h80);
		$display("Flutter test done");
		tally_and_finish();
	end
endmodule
